// ===== hdl/mcr_defs.vh
// register offsets, field positions and reset values of the modem config bank
`ifndef MCR_DEFS_VH
`define MCR_DEFS_VH
// offsets are register indices; the bus byte address is four times one
`define MCR_OFS_BW_EXP      16'hDF0C
`define MCR_OFS_RATE_MANT   16'hDF0D
`define MCR_OFS_MOD_DC      16'hDF0E
`define MCR_RST_BW_EXP      8'h8C
`define MCR_RST_RATE_MANT   8'h22
`define MCR_RST_MOD_DC      8'h00
`define MCR_BWE_HI          7
`define MCR_BWE_LO          6
`define MCR_BWM_HI          5
`define MCR_BWM_LO          4
`define MCR_SRE_HI          3
`define MCR_SRE_LO          0
`define MCR_DCB_BIT         7
`define MCR_MOD_HI          6
`define MCR_MOD_LO          4
`define MCR_MOD_2FSK        3'h0
`define MCR_MOD_GFSK        3'h1
`define MCR_MOD_MSK         3'h7
`define MCR_HIDDEN_ONE      9'h100
`define MCR_BW_BASE         3'h4
`endif

// ===== hdl/mcr_modem_cfg.v
// modem configuration register bank with an ahb-lite slave port
`timescale 1ns/10ps
`include "mcr_defs.vh"

module mcr_modem_cfg (
  input  wire        SYS_CLK,        // system clock, 10 MHz
  input  wire        RST_B,          // synchronous reset, active low
  input  wire        HSEL,           // slave select
  input  wire [31:0] HADDR,          // byte address, word aligned
  input  wire [1:0]  HTRANS,         // transfer type
  input  wire        HWRITE,         // write when high
  input  wire [2:0]  HSIZE,          // transfer size
  input  wire        HREADY,         // bus ready
  input  wire [31:0] HWDATA,         // write data
  output reg  [31:0] HRDATA,         // read data
  output reg         HREADYOUT,      // slave ready
  output reg         HRESP,          // response, always okay
  output reg  [1:0]  BW_EXPONENT,    // channel filter decimation exponent
  output reg  [1:0]  BW_MANTISSA,    // channel filter decimation mantissa
  output reg  [5:0]  BW_DIVISOR,     // (4+mantissa) times 2^exponent
  output reg  [3:0]  SYMRATE_EXPONENT, // symbol rate exponent
  output reg  [8:0]  SYMRATE_MANTISSA, // mantissa with hidden one
  output reg         DC_BLOCK_BYPASS,  // high bypasses the dc blocker
  output reg         MOD_2FSK,       // 2-fsk selected
  output reg         MOD_GFSK,       // gfsk selected
  output reg         MOD_MSK,        // msk selected
  output reg         MOD_RESERVED    // a reserved code is selected
);

  ////////////////////////////////////////////////////////////////////////////
  // overview: three byte-wide registers sit on word addresses of the bus.
  // a transfer is taken at the edge where select, ready and a nonseq or seq
  // type meet; writes land on the following edge from the low byte lane,
  // reads are loaded on the taking edge so the data phase sees them at
  // once. the modem side sees registered copies one edge later, which
  // keeps every output straight from a flop at the cost of a cycle of lag.
  // hsize is not decoded: every register is a whole aligned word, and
  // narrower transfers simply act on the low byte.

  // register select codes returned by the address decode
  localparam [1:0] SEL_NONE      = 2'h0;
  localparam [1:0] SEL_BW_RATE   = 2'h1;
  localparam [1:0] SEL_RATE_MANT = 2'h2;
  localparam [1:0] SEL_MOD_DC    = 2'h3;

  // reset images of the registers split into fields, so the decoded
  // outputs leave reset agreeing with what a read of the bytes returns
  localparam [7:0] RST_BW_RATE   = `MCR_RST_BW_EXP;
  localparam [7:0] RST_RATE_MANT = `MCR_RST_RATE_MANT;
  localparam [7:0] RST_MOD_DC    = `MCR_RST_MOD_DC;
  localparam [1:0] RST_BWE       = RST_BW_RATE[`MCR_BWE_HI:`MCR_BWE_LO];
  localparam [1:0] RST_BWM       = RST_BW_RATE[`MCR_BWM_HI:`MCR_BWM_LO];
  localparam [3:0] RST_SRE       = RST_BW_RATE[`MCR_SRE_HI:`MCR_SRE_LO];
  localparam [0:0] RST_DCB       = RST_MOD_DC[`MCR_DCB_BIT];
  localparam [2:0] RST_MOD       = RST_MOD_DC[`MCR_MOD_HI:`MCR_MOD_LO];

  // word-address decode shared by the write and read paths; the two low
  // address bits are ignored because only whole aligned words are used
  function [1:0] reg_sel;
    input [31:0] a;
    begin
      if (a[31:2] == {14'h0000, `MCR_OFS_BW_EXP})
        reg_sel = SEL_BW_RATE;
      else if (a[31:2] == {14'h0000, `MCR_OFS_RATE_MANT})
        reg_sel = SEL_RATE_MANT;
      else if (a[31:2] == {14'h0000, `MCR_OFS_MOD_DC})
        reg_sel = SEL_MOD_DC;
      else
        reg_sel = SEL_NONE;
    end
  endfunction

  // one-hot decode of the modulation selector; every code not listed is
  // reserved and raises only the reserved flag, so the modem never sees
  // two formats at once
  function [3:0] mode_flags;
    input [2:0] s;
    begin
      case (s)
        `MCR_MOD_2FSK: mode_flags = 4'h8;
        `MCR_MOD_GFSK: mode_flags = 4'h4;
        `MCR_MOD_MSK:  mode_flags = 4'h2;
        default:       mode_flags = 4'h1;
      endcase
    end
  endfunction

  // divisor of the channel filter excluding the fixed factor 8
  function [5:0] bw_div;
    input [1:0] m;
    input [1:0] e;
    begin
      bw_div = {3'h0, `MCR_BW_BASE + {1'b0, m}} << e;
    end
  endfunction

  reg  [7:0]  bw_rate_q;
  reg  [7:0]  rate_mant_q;
  reg  [7:0]  mod_dc_q;
  reg  [31:0] addr_q;
  reg         wr_q;
  reg         rd_q;
  reg  [7:0]  rdata_d;
  wire        take;
  wire [2:0]  modsel;
  wire [1:0]  wsel;
  wire [1:0]  rsel;

  ////////////////////////////////////////////////////////////////////////////
  // address phase capture; every access finishes with no wait state
  assign take = HSEL & HREADY & HTRANS[1];

  // write decode uses the captured address, since in the data phase the
  // address lines may already carry the next transfer
  assign wsel = reg_sel(addr_q);
  assign rsel = reg_sel(HADDR);

  always @(posedge SYS_CLK) begin
    if (!RST_B) begin
      addr_q    <= 32'h0000_0000;
      wr_q      <= 1'b0;
      rd_q      <= 1'b0;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end else begin
      addr_q    <= HADDR;
      wr_q      <= take & HWRITE;
      rd_q      <= take & ~HWRITE;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register writes in the data phase; only the low byte lane is stored
  always @(posedge SYS_CLK) begin
    if (!RST_B) begin
      bw_rate_q   <= `MCR_RST_BW_EXP;
      rate_mant_q <= `MCR_RST_RATE_MANT;
      mod_dc_q    <= `MCR_RST_MOD_DC;
    end else if (wr_q) begin
      case (wsel)
        SEL_BW_RATE:   bw_rate_q   <= HWDATA[7:0];
        SEL_RATE_MANT: rate_mant_q <= HWDATA[7:0];
        SEL_MOD_DC:    mod_dc_q    <= HWDATA[7:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux, unmapped addresses read zero; low mod_dc bits stay stored
  always @* begin
    case (rsel)
      SEL_BW_RATE:   rdata_d = bw_rate_q;
      SEL_RATE_MANT: rdata_d = rate_mant_q;
      SEL_MOD_DC:    rdata_d = mod_dc_q;
      default:            rdata_d = 8'h00;
    endcase
  end

  // read data registered at the address edge so it stands in the data phase
  always @(posedge SYS_CLK) begin
    if (!RST_B) begin
      HRDATA <= 32'h0000_0000;
    end else if (take & ~HWRITE) begin
      HRDATA <= {24'h00_0000, rdata_d};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decoded controls to the modem, registered so outputs come from flops
  assign modsel = mod_dc_q[`MCR_MOD_HI:`MCR_MOD_LO];

  always @(posedge SYS_CLK) begin
    if (!RST_B) begin
      BW_EXPONENT      <= RST_BWE;
      BW_MANTISSA      <= RST_BWM;
      BW_DIVISOR       <= bw_div(RST_BWM, RST_BWE);
      SYMRATE_EXPONENT <= RST_SRE;
      SYMRATE_MANTISSA <= `MCR_HIDDEN_ONE | {1'b0, RST_RATE_MANT};
      DC_BLOCK_BYPASS  <= RST_DCB;
      {MOD_2FSK, MOD_GFSK, MOD_MSK, MOD_RESERVED} <= mode_flags(RST_MOD);
    end else begin
      BW_EXPONENT      <= bw_rate_q[`MCR_BWE_HI:`MCR_BWE_LO];
      BW_MANTISSA      <= bw_rate_q[`MCR_BWM_HI:`MCR_BWM_LO];
      BW_DIVISOR       <= bw_div(bw_rate_q[`MCR_BWM_HI:`MCR_BWM_LO],
                                 bw_rate_q[`MCR_BWE_HI:`MCR_BWE_LO]);
      SYMRATE_EXPONENT <= bw_rate_q[`MCR_SRE_HI:`MCR_SRE_LO];
      // hidden leading one restores the 9-bit mantissa
      SYMRATE_MANTISSA <= `MCR_HIDDEN_ONE | {1'b0, rate_mant_q};
      DC_BLOCK_BYPASS  <= mod_dc_q[`MCR_DCB_BIT];
      // rate limits on msk and gfsk are left to software, not checked here
      {MOD_2FSK, MOD_GFSK, MOD_MSK, MOD_RESERVED} <= mode_flags(modsel);
    end
  end

endmodule // mcr_modem_cfg

// ===== tb/mcr_modem_cfg_assertions.sv
// port checker for the modem configuration bank
`timescale 1ns/10ps
module mcr_chk (
  input wire SYS_CLK, RST_B, HSEL, HWRITE, HREADY, // clock and bus control
  input wire DC_BLOCK_BYPASS, MOD_2FSK, MOD_GFSK, MOD_MSK, MOD_RESERVED,
  input wire [1:0] HTRANS, BW_EXPONENT, BW_MANTISSA, // bus and bw fields
  input wire [3:0] SYMRATE_EXPONENT, input wire [5:0] BW_DIVISOR,
  input wire [8:0] SYMRATE_MANTISSA, input wire [31:0] HADDR,
  input wire [31:0] HWDATA, HRDATA); // data buses
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);
  // taken transfers and their byte offset from the first register word
  wire tk = HSEL && HREADY && HTRANS[1], w = tk && HWRITE;
  wire [31:0] a = HADDR - 32'h0003_7C30;
  wire [7:0] d = HWDATA[7:0];
  wire [3:0] md = {MOD_2FSK, MOD_GFSK, MOD_MSK, MOD_RESERVED};
  wire ru = tk && !HWRITE && a != 32'h0 && a != 32'h4 && a != 32'h8;
  //////////////////////////////////////////////////////////////////////////////
  // decoded outputs land one edge after the data phase edge and are checked at the next edge
  property p_div; BW_DIVISOR == (6'h4+BW_MANTISSA)<<BW_EXPONENT; endproperty
  a_div: assert property (p_div) else $error("bad divisor");
  property p_sre; w && a == 0 |=> ##2 SYMRATE_EXPONENT == $past(d[3:0],2);
  endproperty
  a_sre: assert property (p_sre) else $error("bad exponent");
  property p_srm; w && a == 4 |=> ##2 SYMRATE_MANTISSA == {1'b1,$past(d,2)};
  endproperty
  a_srm: assert property (p_srm) else $error("bad mantissa");
  property p_one; $onehot(md); endproperty
  a_one: assert property (p_one) else $error("mode flags not one-hot");
  property p_dcb; w && a == 8 |=> ##2 DC_BLOCK_BYPASS == $past(d[7],2);
  endproperty
  a_dcb: assert property (p_dcb) else $error("bad bypass");
  property p_unm; ru |=> HRDATA == 32'h0; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  c_wr: cover property (w && a == 8);
  c_ru: cover property (ru);
  c_msk: cover property (MOD_MSK);
endmodule // mcr_chk
bind mcr_modem_cfg mcr_chk u_chk (
  .SYS_CLK(SYS_CLK), .RST_B(RST_B), .HSEL(HSEL), .HWRITE(HWRITE),
  .HREADY(HREADY), .DC_BLOCK_BYPASS(DC_BLOCK_BYPASS),
  .MOD_2FSK(MOD_2FSK), .MOD_GFSK(MOD_GFSK), .MOD_MSK(MOD_MSK),
  .MOD_RESERVED(MOD_RESERVED), .HTRANS(HTRANS),
  .BW_EXPONENT(BW_EXPONENT), .BW_MANTISSA(BW_MANTISSA),
  .SYMRATE_EXPONENT(SYMRATE_EXPONENT), .BW_DIVISOR(BW_DIVISOR),
  .SYMRATE_MANTISSA(SYMRATE_MANTISSA), .HADDR(HADDR), .HWDATA(HWDATA),
  .HRDATA(HRDATA));

// ===== tb/mcr_modem_cfg_tb.sv
// self-checking bench for the modem configuration bank
`timescale 1ns/10ps
module mcr_modem_cfg_tb;
  logic SYS_CLK, RST_B, HSEL, HWRITE, HREADYOUT, HRESP, rd_ph = 1'b0;
  logic DC_BLOCK_BYPASS, MOD_2FSK, MOD_GFSK, MOD_MSK, MOD_RESERVED;
  logic [1:0] HTRANS, BW_EXPONENT, BW_MANTISSA;
  logic [2:0] HSIZE = 3'h2;
  logic [3:0] SYMRATE_EXPONENT, m;
  logic [5:0] BW_DIVISOR;
  logic [8:0] SYMRATE_MANTISSA;
  logic [31:0] HADDR;
  logic [31:0] HWDATA, HRDATA, exp_q[$];
  logic [7:0] r[4];
  int miscompares, checked, i, k;
  wire HREADY = HREADYOUT; // the lone slave drives bus ready
  mcr_modem_cfg dut (
    .SYS_CLK(SYS_CLK), .RST_B(RST_B), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HREADY(HREADY),
    .HWDATA(HWDATA), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
    .HRESP(HRESP), .BW_EXPONENT(BW_EXPONENT), .BW_MANTISSA(BW_MANTISSA),
    .BW_DIVISOR(BW_DIVISOR), .SYMRATE_EXPONENT(SYMRATE_EXPONENT),
    .SYMRATE_MANTISSA(SYMRATE_MANTISSA), .DC_BLOCK_BYPASS(DC_BLOCK_BYPASS),
    .MOD_2FSK(MOD_2FSK), .MOD_GFSK(MOD_GFSK), .MOD_MSK(MOD_MSK),
    .MOD_RESERVED(MOD_RESERVED));
  initial begin SYS_CLK = 1'b0; forever #50 SYS_CLK = ~SYS_CLK; end
  task chk(input [31:0] e, g);
    checked++;
    if (g !== e) $display("unexpected at %0t: %h vs %h", $time, e, g);
    if (g !== e) miscompares++;
  endtask
  // one single transfer, each phase held until hready is seen high
  task xfer(input w, input [31:0] a, input [31:0] d);
    if (!w) exp_q.push_back(d);
    {HSEL, HTRANS, HWRITE, HADDR} <= {1'b1, 2'h2, w, a};
    do @(posedge SYS_CLK); while (HREADYOUT !== 1'b1);
    {HSEL, HTRANS, HWDATA} <= {1'b0, 2'h0, d};
    do @(posedge SYS_CLK); while (HREADYOUT !== 1'b1);
  endtask
  // a read data phase ends: compare with the oldest note
  always @(posedge SYS_CLK) begin
    if (rd_ph && HREADYOUT === 1'b1) chk(exp_q.pop_front(), HRDATA);
    if (rd_ph && HREADYOUT === 1'b1) chk(32'h0, HRESP); // okay response
    if (HREADYOUT === 1'b1) rd_ph <= HSEL && HTRANS[1] && !HWRITE;
  end
  task conclude;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin #100000; miscompares++; conclude; end // hang guard
  // second pass resets mid-run, after the random writes
  initial begin
    {RST_B, HSEL, HWRITE, HTRANS, HADDR, HWDATA} = '0;
    void'($urandom(32'h0F01F7C7));
    for (k = 0; k < 2; k++) begin
      RST_B <= 1'b0;
      repeat (2) @(posedge SYS_CLK);
      RST_B <= 1'b1;
      @(posedge SYS_CLK);
      chk({SYMRATE_MANTISSA, MOD_2FSK}, {9'h122, 1'b1});
      r = '{8'h8C, 8'h22, 8'h00, 8'h00}; // last entry is unmapped
      for (i = 0; i < 9; i++) begin
        for (int j = 0; j < 4; j++)
          xfer(1'b0, 32'h0003_7C30 + 32'(4 * j), r[j]);
        if (i == 8) break;
        {r[0], r[1], r[2]} = {16'($urandom), 1'($urandom), 3'(i), 4'($urandom)};
        // 26 MHz reference assumed: exponent 11 gives 51 to 101 kBaud
        if (i == 1 || i == 7) r[0][3:0] = 4'hB;
        if (r[0][3:0] > 4'hA) r[2][7] = 1'b0;
        for (int j = 0; j < 4; j++)
          xfer(1'b1, 32'h0003_7C30 + 32'(4 * j),
               {24'($urandom), r[j]});
        m = {i == 0, i == 1, i == 7, i > 1 && i < 7};
        chk({BW_EXPONENT, BW_MANTISSA, SYMRATE_EXPONENT}, r[0]);
        chk({MOD_2FSK, MOD_GFSK, MOD_MSK, MOD_RESERVED}, m);
        chk(DC_BLOCK_BYPASS, r[2][7]);
        chk(BW_DIVISOR, (6'h4 + r[0][5:4]) << r[0][7:6]);
        chk(SYMRATE_MANTISSA, 9'h100 + r[1]);
      end
      $display("pass %0d done", k);
    end
    @(posedge SYS_CLK);
    conclude;
  end
endmodule // mcr_modem_cfg_tb
